/* File: core/kpr_core.sv */
// Overview of operation
// - Pointer steps 1..5 upward, 6 wraps to 0, 0 stays at 0.
// - Pointer advances after each data byte written or read byte taken inside a burst.
// - First read byte comes from the stored pointer register.
// - Third key closing a matrix rectangle is withheld from reporting.
// - Any number of keys accepted while no ghost and queue not full.
// - Keys monitored statically; debounce runs only while a key is pressed.
// - Configuration bit 7 reads 1 in normal operating mode.
// - Writing bit 7 to 0 then 1 restarts the key-detection sequencer.
// - First byte after address in a write is the command byte.
// - Command byte followed by stop only loads the pointer.
`default_nettype none
module kpr_core #(
    parameter int ROWS = kpr_pkg::ROWS,
    parameter int COLS = kpr_pkg::COLS,
    parameter int QUEUE_DEPTH = kpr_pkg::QUEUE_DEPTH
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Decoded serial bus byte events
    input wire logic bus_start,
    input wire logic bus_stop,
    input wire logic bus_rx_valid,
    input wire logic [7:0] bus_rx_byte,
    input wire logic bus_tx_take,
    // Key matrix, one bit per switch, row major
    input wire logic [ROWS*COLS-1:0] key_down,
    // Read data and status
    output logic [7:0] tx_byte,
    output logic [7:0] pointer,
    output logic [7:0] config_reg,
    output logic [7:0] sleep_reg,
    output logic [7:0] key_event,
    output logic key_event_valid,
    output logic seq_active
);
    localparam int NK = ROWS * COLS;
    logic expect_cmd;
    logic next_expect_cmd;
    logic [7:0] next_pointer;
    logic [7:0] next_tx_byte;
    logic wr_en;
    logic [7:0] config_q;
    logic [7:0] sleep_q;
    logic cfg_bit_cleared;
    logic next_cfg_bit_cleared;
    logic seq_restart;
    kpr_pkg::kpr_seq_t seq;
    kpr_pkg::kpr_seq_t next_seq;
    logic [7:0] settle;
    logic [7:0] next_settle;
    logic [NK-1:0] accepted;
    logic [NK-1:0] next_accepted;
    logic [7:0] next_key_event;
    logic next_key_event_valid;
    logic [$clog2(QUEUE_DEPTH+1)-1:0] queue_fill;
    logic [$clog2(QUEUE_DEPTH+1)-1:0] next_queue_fill;

    function automatic logic [7:0] step_ptr(input logic [7:0] p);
        if (p == kpr_pkg::ADDR_KEY_QUEUE || p == kpr_pkg::ADDR_SLEEP) begin
            step_ptr = kpr_pkg::ADDR_KEY_QUEUE;
        end else if (p <= kpr_pkg::ADDR_LAST_INC) begin
            step_ptr = p + 8'h01;
        end else begin
            step_ptr = p;
        end
    endfunction : step_ptr

    // Would pressing key k with the accepted set complete a rectangle corner trio
    function automatic logic makes_ghost(input logic [NK-1:0] acc, input int k);
        int r;
        int c;
        makes_ghost = 1'b0;
        for (int r2 = 0; r2 < ROWS; r2++) begin
            for (int c2 = 0; c2 < COLS; c2++) begin
                r = k / COLS;
                c = k % COLS;
                if (r2 != r && c2 != c) begin
                    if ((acc[r*COLS+c2] && acc[r2*COLS+c2]) ||
                        (acc[r2*COLS+c] && acc[r2*COLS+c2]) ||
                        (acc[r*COLS+c2] && acc[r2*COLS+c])) begin
                        makes_ghost = 1'b1;
                    end
                end
            end
        end
    endfunction : makes_ghost

    always_comb begin
        next_expect_cmd = expect_cmd;
        next_pointer = pointer;
        wr_en = 1'b0;
        if (bus_start || bus_stop) begin
            next_expect_cmd = 1'b1;
        end else if (bus_rx_valid && expect_cmd) begin
            next_pointer = bus_rx_byte;
            next_expect_cmd = 1'b0;
        end else if (bus_rx_valid) begin
            wr_en = 1'b1;
            next_pointer = step_ptr(pointer);
        end else if (bus_tx_take) begin
            next_pointer = step_ptr(pointer);
        end
    end

    always_comb begin
        case (pointer)
            kpr_pkg::ADDR_KEY_QUEUE: next_tx_byte = key_event_valid ? key_event
                                                  : kpr_pkg::QUEUE_EMPTY_CODE;
            kpr_pkg::ADDR_CONFIG: next_tx_byte = config_q;
            kpr_pkg::ADDR_SLEEP: next_tx_byte = sleep_q;
            default: next_tx_byte = 8'h00;
        endcase
    end

    kpr_regs u_regs (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .wr_en(wr_en),
        .wr_addr(pointer),
        .wr_data(bus_rx_byte),
        .config_q(config_q),
        .sleep_q(sleep_q)
    );

    always_comb begin
        next_cfg_bit_cleared = cfg_bit_cleared;
        seq_restart = 1'b0;
        if (wr_en && pointer == kpr_pkg::ADDR_CONFIG) begin
            if (!bus_rx_byte[kpr_pkg::CFG_RUN_BIT]) begin
                next_cfg_bit_cleared = 1'b1;
            end else if (cfg_bit_cleared) begin
                seq_restart = 1'b1;
                next_cfg_bit_cleared = 1'b0;
            end
        end
    end

    always_comb begin
        next_seq = seq;
        next_settle = settle;
        next_accepted = accepted & key_down;
        next_key_event = key_event;
        next_key_event_valid = key_event_valid;
        next_queue_fill = queue_fill;
        if (bus_tx_take && pointer == kpr_pkg::ADDR_KEY_QUEUE && key_event_valid) begin
            next_key_event_valid = 1'b0;
            if (queue_fill != '0) begin
                next_queue_fill = queue_fill - 1'b1;
            end
        end
        if (seq_restart || !config_q[kpr_pkg::CFG_RUN_BIT]) begin
            next_seq = kpr_pkg::KPR_IDLE;
            next_settle = 8'h00;
            next_accepted = '0;
        end else begin
            case (seq)
                kpr_pkg::KPR_IDLE: begin
                    // Debounce sits still until current draw shows a press
                    if (key_down != '0) begin
                        next_seq = kpr_pkg::KPR_DEBOUNCE;
                        next_settle = 8'h00;
                    end
                end
                kpr_pkg::KPR_DEBOUNCE: begin
                    if (key_down == '0) begin
                        next_seq = kpr_pkg::KPR_IDLE;
                    end else if (settle == kpr_pkg::SEQ_SETTLE) begin
                        next_seq = kpr_pkg::KPR_HOLD;
                    end else begin
                        next_settle = settle + 8'h01;
                    end
                end
                kpr_pkg::KPR_HOLD: begin
                    if (key_down == '0) begin
                        next_seq = kpr_pkg::KPR_IDLE;
                    end
                    // One new key per cycle; ghost makers and full queue are held back
                    for (int k = NK - 1; k >= 0; k--) begin
                        if (key_down[k] && !accepted[k] && !makes_ghost(accepted, k) &&
                            queue_fill < QUEUE_DEPTH[$bits(queue_fill)-1:0] &&
                            !next_key_event_valid) begin
                            next_accepted = (accepted & key_down) |
                                            (NK'(1) << k);
                            next_key_event = 8'(k);
                            next_key_event_valid = 1'b1;
                        end
                    end
                    // A take and a fresh load in one cycle must still count the load
                    if (next_key_event_valid && (!key_event_valid ||
                        (bus_tx_take && pointer == kpr_pkg::ADDR_KEY_QUEUE))) begin
                        next_queue_fill = next_queue_fill + 1'b1;
                    end
                end
                default: next_seq = kpr_pkg::KPR_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            expect_cmd <= 1'b1;
            pointer <= kpr_pkg::ADDR_KEY_QUEUE;
            tx_byte <= 8'h00;
            cfg_bit_cleared <= 1'b0;
            seq <= kpr_pkg::KPR_IDLE;
            settle <= 8'h00;
            accepted <= '0;
            key_event <= 8'h00;
            key_event_valid <= 1'b0;
            queue_fill <= '0;
            config_reg <= kpr_pkg::CONFIG_RESET;
            sleep_reg <= kpr_pkg::SLEEP_RESET;
            seq_active <= 1'b0;
        end else begin
            expect_cmd <= next_expect_cmd;
            pointer <= next_pointer;
            tx_byte <= next_tx_byte;
            cfg_bit_cleared <= next_cfg_bit_cleared;
            seq <= next_seq;
            settle <= next_settle;
            accepted <= next_accepted;
            key_event <= next_key_event;
            key_event_valid <= next_key_event_valid;
            queue_fill <= next_queue_fill;
            config_reg <= config_q;
            sleep_reg <= sleep_q;
            seq_active <= next_seq != kpr_pkg::KPR_IDLE;
        end
    end

    a_ptr_wrap: assert property (@(posedge ref_clk) disable iff (!rstn)
        (bus_rx_valid && !expect_cmd && !bus_start && !bus_stop && pointer == kpr_pkg::ADDR_SLEEP)
        |=> pointer == kpr_pkg::ADDR_KEY_QUEUE) else $error("Pointer did not wrap");
    a_ptr_step: assert property (@(posedge ref_clk) disable iff (!rstn)
        (bus_tx_take && !bus_rx_valid && !bus_start && !bus_stop &&
         pointer >= kpr_pkg::ADDR_CONFIG && pointer <= kpr_pkg::ADDR_LAST_INC)
        |=> pointer == $past(pointer) + 8'h01) else $error("Pointer did not step");
    a_cmd_load: assert property (@(posedge ref_clk) disable iff (!rstn)
        (bus_rx_valid && expect_cmd && !bus_start && !bus_stop)
        |=> pointer == $past(bus_rx_byte) && !expect_cmd) else $error("Command not loaded");
    a_cmd_only: assert property (@(posedge ref_clk) disable iff (!rstn)
        (bus_rx_valid && expect_cmd) |=> $stable(config_q) && $stable(sleep_q))
        else $error("Command byte changed a register");
    a_idle_still: assert property (@(posedge ref_clk) disable iff (!rstn)
        (key_down == '0 && seq == kpr_pkg::KPR_IDLE) |=> seq == kpr_pkg::KPR_IDLE)
        else $error("Debounce ran with no key");
    a_seq_reset: assert property (@(posedge ref_clk) disable iff (!rstn)
        seq_restart |=> seq == kpr_pkg::KPR_IDLE && accepted == '0)
        else $error("Sequencer not restarted");
    a_first_read: assert property (@(posedge ref_clk) disable iff (!rstn)
        (pointer == kpr_pkg::ADDR_CONFIG) |=> tx_byte == $past(config_q))
        else $error("Read byte not from pointer");
    a_queue_cap: assert property (@(posedge ref_clk) disable iff (!rstn)
        queue_fill <= QUEUE_DEPTH[$bits(queue_fill)-1:0]) else $error("Queue overfilled");
    a_cfg_mirror: assert property (@(posedge ref_clk) disable iff (!rstn)
        1'b1 |=> config_reg == $past(config_q)) else $error("Config not shown");
    c_burst: cover property (@(posedge ref_clk) disable iff (!rstn)
        bus_rx_valid && !expect_cmd ##1 bus_rx_valid);
    c_restart: cover property (@(posedge ref_clk) disable iff (!rstn) seq_restart);
    c_event: cover property (@(posedge ref_clk) disable iff (!rstn) $rose(key_event_valid));
endmodule : kpr_core
`default_nettype wire

/* File: core/kpr_pkg.sv */
`default_nettype none
package kpr_pkg;
    localparam logic [7:0] ADDR_KEY_QUEUE = 8'h00;
    localparam logic [7:0] ADDR_CONFIG = 8'h01;
    localparam logic [7:0] ADDR_LAST_INC = 8'h05;
    localparam logic [7:0] ADDR_SLEEP = 8'h06;
    localparam int CFG_RUN_BIT = 7;
    localparam logic [7:0] CONFIG_RESET = 8'h80;
    localparam logic [7:0] SLEEP_RESET = 8'h07;
    localparam logic [7:0] QUEUE_EMPTY_CODE = 8'h3F;
    localparam int ROWS = 8;
    localparam int COLS = 8;
    localparam int QUEUE_DEPTH = 16;
    localparam logic [7:0] SEQ_SETTLE = 8'h04;
    typedef enum logic [1:0] {KPR_IDLE, KPR_DEBOUNCE, KPR_HOLD} kpr_seq_t;
endpackage : kpr_pkg
`default_nettype wire

/* File: core/kpr_regs.sv */
`default_nettype none
module kpr_regs (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Write strobe
    input wire logic wr_en,
    input wire logic [7:0] wr_addr,
    input wire logic [7:0] wr_data,
    // Stored values
    output logic [7:0] config_q,
    output logic [7:0] sleep_q
);
    logic [7:0] next_config;
    logic [7:0] next_sleep;
    always_comb begin
        next_config = config_q;
        next_sleep = sleep_q;
        if (wr_en && wr_addr == kpr_pkg::ADDR_CONFIG) begin
            next_config = wr_data;
        end
        if (wr_en && wr_addr == kpr_pkg::ADDR_SLEEP) begin
            next_sleep = wr_data;
        end
    end
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            config_q <= kpr_pkg::CONFIG_RESET;
            sleep_q <= kpr_pkg::SLEEP_RESET;
        end else begin
            config_q <= next_config;
            sleep_q <= next_sleep;
        end
    end
endmodule : kpr_regs
`default_nettype wire

/* File: dv/kpr_master_model.sv */
`default_nettype none
module kpr_master_model (
    // Clock
    input wire logic ref_clk,
    // Byte events toward the device
    output logic bus_start,
    output logic bus_stop,
    output logic bus_rx_valid,
    output logic [7:0] bus_rx_byte,
    output logic bus_tx_take
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        {bus_start, bus_stop, bus_rx_valid, bus_tx_take} = 4'h0;
        bus_rx_byte = 8'h00;
    end

    // Kinds: 0 start, 1 stop, 2 byte, 3 read byte taken
    task automatic ev(input int kind, input logic [7:0] b);
        @(posedge ref_clk);
        #5;
        bus_start = (kind == 0);
        bus_stop = (kind == 1);
        bus_rx_valid = (kind == 2);
        bus_tx_take = (kind == 3);
        bus_rx_byte = b;
        @(posedge ref_clk);
        #5;
        {bus_start, bus_stop, bus_rx_valid, bus_tx_take} = 4'h0;
        // Released data shows the inverse so a stale byte cannot pass as fresh
        bus_rx_byte = ~b;
    endtask : ev

    // Command byte first, then one data byte, then stop
    task automatic wr1(input logic [7:0] a, input logic [7:0] d);
        ev(0, 8'h00);
        ev(2, a);
        ev(2, d);
        ev(1, 8'h00);
    endtask : wr1

    // Pointer re-sent before any read; repeated start keeps other masters out
    task automatic set_ptr(input logic [7:0] a);
        ev(0, 8'h00);
        ev(2, a);
        ev(0, 8'h00);
    endtask : set_ptr
endmodule : kpr_master_model
`default_nettype wire

/* File: dv/test_keypad_i2c_register_pointer.sv */
`default_nettype none
module test_keypad_i2c_register_pointer;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk;
    logic rstn;
    logic bus_start, bus_stop, bus_rx_valid, bus_tx_take;
    logic [7:0] bus_rx_byte;
    logic [63:0] key_down;
    logic [7:0] tx_byte, pointer, config_reg, sleep_reg, key_event;
    logic key_event_valid, seq_active;
    int failures = 0;
    int cmp_count = 0;

    kpr_core DUT (.ref_clk(ref_clk), .rstn(rstn), .bus_start(bus_start), .bus_stop(bus_stop),
        .bus_rx_valid(bus_rx_valid), .bus_rx_byte(bus_rx_byte), .bus_tx_take(bus_tx_take),
        .key_down(key_down), .tx_byte(tx_byte), .pointer(pointer), .config_reg(config_reg),
        .sleep_reg(sleep_reg), .key_event(key_event), .key_event_valid(key_event_valid),
        .seq_active(seq_active));
    kpr_master_model M (.ref_clk(ref_clk), .bus_start(bus_start), .bus_stop(bus_stop),
        .bus_rx_valid(bus_rx_valid), .bus_rx_byte(bus_rx_byte), .bus_tx_take(bus_tx_take));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic complete_run();
        if (failures == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #5;
    endtask : tick

    // Bounded wait; running out ends the run as a failure
    task automatic wait_seq(input logic exp);
        for (int i = 0; i < 300; i++) begin
            if (seq_active === exp) return;
            tick(1);
        end
        failures++;
        complete_run();
    endtask : wait_seq

    task automatic t_reset();
        check(pointer, 8'h00);
        check(config_reg, 8'h80);
        check(sleep_reg, 8'h07);
        check({7'h00, seq_active}, 8'h00);
    endtask : t_reset

    // Burst across 1..6, the wrap to 0 and the hold at 0
    task automatic t_burst();
        logic [7:0] a;
        logic [7:0] d;
        a = 8'h01;
        M.ev(0, 8'h00);
        M.ev(2, 8'h01);
        check(pointer, 8'h01);
        for (int i = 0; i < 7; i++) begin
            d = (a == 8'h01) ? 8'h85 : 8'hA0 + 8'(i);
            M.ev(2, d);
            a = (a == 8'h06 || a == 8'h00) ? 8'h00 : a + 8'h01;
            check(pointer, a);
        end
        M.ev(1, 8'h00);
        tick(2);
        check(sleep_reg, 8'hA5);
        check(config_reg, 8'h85);
    endtask : t_burst

    task automatic t_cmd_only();
        M.ev(0, 8'h00);
        M.ev(2, 8'h06);
        M.ev(1, 8'h00);
        tick(2);
        check(pointer, 8'h06);
        check(sleep_reg, 8'hA5);
    endtask : t_cmd_only

    task automatic t_read();
        tick(1);
        check(tx_byte, 8'hA5);
        M.ev(3, 8'h00);
        check(pointer, 8'h00);
        tick(1);
        check(tx_byte, 8'h3F);
        M.ev(3, 8'h00);
        check(pointer, 8'h00);
    endtask : t_read

    // A byte after a new start is a command, not a continuation of the last burst
    task automatic t_single();
        M.wr1(8'h06, 8'h09);
        M.ev(0, 8'h00);
        M.ev(2, 8'h01);
        check(pointer, 8'h01);
        tick(2);
        check(sleep_reg, 8'h09);
    endtask : t_single

    task automatic t_verify();
        M.wr1(8'h01, 8'h80);
        check(pointer, 8'h02);
        M.set_ptr(8'h01);
        tick(1);
        check(tx_byte, 8'h80);
        M.ev(3, 8'h00);
        check(pointer, 8'h02);
    endtask : t_verify

    task automatic t_keys();
        int n;
        logic [7:0] seen;
        n = 0;
        seen = 8'h00;
        tick(20);
        check({7'h00, seq_active}, 8'h00);
        key_down[0] = 1'b1;
        key_down[1] = 1'b1;
        wait_seq(1'b1);
        tick(40);
        M.set_ptr(8'h00);
        for (int i = 0; i < 8 && key_event_valid === 1'b1; i++) begin
            seen = seen | (8'h01 << key_event);
            M.ev(3, 8'h00);
            tick(1);
            n++;
        end
        check(8'(n), 8'h02);
        check(seen, 8'h03);
        // Row 1 column 0 closes a rectangle with the two held keys
        key_down[8] = 1'b1;
        tick(60);
        check({7'h00, key_event_valid}, 8'h00);
    endtask : t_keys

    task automatic t_restart();
        M.wr1(8'h01, 8'h00);
        tick(2);
        check(config_reg, 8'h00);
        wait_seq(1'b0);
        M.wr1(8'h01, 8'h80);
        wait_seq(1'b1);
        check(config_reg, 8'h80);
    endtask : t_restart

    initial begin
        rstn = 1'b0;
        key_down = '0;
        repeat (12) @(posedge ref_clk);
        #5;
        rstn = 1'b1;
        t_reset();
        t_burst();
        t_cmd_only();
        t_read();
        t_single();
        t_verify();
        t_keys();
        t_restart();
        complete_run();
    end
endmodule : test_keypad_i2c_register_pointer
`default_nettype wire
